/* rtl/cmp_ctrl.sv */
// Comparator output, filter, flag and interrupt control with AXI4-Lite.
// Assumes the raw comparator and strobe inputs are asynchronous; mux
// selects, pin ownership and stop mode come from logic on clk.
`timescale 1ns/1ns
module cmp_ctrl
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire axi_req_s axi_req,
  output axi_rsp_s axi_rsp,
  // Analog side
  input wire logic raw_in,
  input wire logic sample_in,
  input wire logic [2:0] plus_sel,
  input wire logic [2:0] minus_sel,
  output logic cmp_enable,
  // System side
  input wire logic pin_owned,
  input wire logic stop_mode,
  output logic pin_out,
  output logic pin_oe,
  output logic dma_req,
  output logic irq
);
  state_s st_q;
  state_s st_d;

  // Next state
  always_comb begin
    logic flip;
    logic tick;
    logic raw_pol;
    logic sel;
    logic rise_set;
    logic fall_set;
    logic rise_clr;
    logic fall_clr;
    logic stat_clr;
    logic unmapped_w;
    logic unmapped_r;
    logic [7:0] rbyte;
    logic [5:0] ridx;
    logic [5:0] widx;
    flip = 1'b0;
    tick = 1'b0;
    raw_pol = 1'b0;
    sel = 1'b0;
    rise_set = 1'b0;
    fall_set = 1'b0;
    rise_clr = 1'b0;
    fall_clr = 1'b0;
    stat_clr = 1'b0;
    unmapped_w = 1'b0;
    unmapped_r = 1'b0;
    rbyte = 8'h00;
    ridx = axi_req.araddr[7:2];
    widx = st_q.waddr[7:2];
    st_d = st_q;

    // Synchronisers for asynchronous inputs
    st_d.raw_s1 = raw_in;
    st_d.raw_s2 = st_q.raw_s1;
    st_d.smp_s1 = sample_in;
    st_d.smp_s2 = st_q.smp_s1;
    st_d.smp_prev = st_q.smp_s2;

    // Comparator power with mux conflict shutdown
    st_d.enable = st_q.out_ctrl[OC_ON] && (plus_sel != minus_sel); // R3 R4

    // Polarity applied to the raw result
    flip = st_q.out_ctrl[OC_FLIP];
    raw_pol = st_q.raw_s2 ^ flip; // R5

    // Sample tick from strobe edge or interval counter
    if (st_q.out_ctrl[OC_STROBE]) begin
      tick = st_q.smp_s2 & ~st_q.smp_prev; // R8
      st_d.cnt = 8'h00;
    end else if (st_q.interval == 8'h00) begin
      st_d.cnt = 8'h00; // R7
    end else if (st_q.cnt >= st_q.interval - 8'h01) begin
      tick = 1'b1; // R6
      st_d.cnt = 8'h00;
    end else begin
      st_d.cnt = st_q.cnt + 8'h01;
    end

    // Filter acts as a sampler; bypassed when disabled
    if (!st_q.out_ctrl[OC_STROBE] && st_q.interval == 8'h00) begin
      st_d.filt = raw_pol; // R7
    end else if (tick) begin
      st_d.filt = raw_pol;
    end

    // Output source pick
    sel = st_q.out_ctrl[OC_SRC] ? raw_pol : st_q.filt; // R1
    // Result mirrors polarity flip while off
    st_d.result = st_q.enable ? sel : flip; // R16 R18
    st_d.result_prev = st_q.result;

    // Edge or level detection for flags
    if (stop_mode) begin
      rise_set = st_q.result; // R14
      fall_set = ~st_q.result; // R14
    end else begin
      rise_set = st_q.result & ~st_q.result_prev; // R12
      fall_set = ~st_q.result & st_q.result_prev; // R13
    end

    // Write address and data taken in either order
    if (axi_req.awvalid && st_q.rsp.awready) begin
      st_d.aw_got = 1'b1;
      st_d.waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_q.rsp.wready) begin
      st_d.w_got = 1'b1;
      st_d.wbyte = axi_req.wdata[7:0];
      st_d.wen = axi_req.wstrb[0];
    end

    // Register write once both halves are in
    if (st_q.aw_got && st_q.w_got && !st_q.rsp.bvalid) begin
      unmapped_w = 1'b0;
      if (st_q.wen) begin
        case (widx)
          IDX_OUT_CTRL: st_d.out_ctrl = st_q.wbyte;
          IDX_INTERVAL: st_d.interval = st_q.wbyte;
          IDX_STAT_CTRL: begin
            st_d.dma_on = st_q.wbyte[SC_DMA];
            st_d.rise_ie = st_q.wbyte[SC_RIE];
            st_d.fall_ie = st_q.wbyte[SC_FIE];
            rise_clr = st_q.wbyte[SC_RISE]; // R12
            fall_clr = st_q.wbyte[SC_FALL]; // R13
          end
          IDX_IRQ_STAT: begin
          end
          IDX_IRQ_MASK: begin
            st_d.irq_mask = st_q.wbyte[1:0];
          end
          default: unmapped_w = 1'b1;
        endcase
      end else if (widx != IDX_OUT_CTRL && widx != IDX_INTERVAL
                   && widx != IDX_STAT_CTRL && widx != IDX_IRQ_STAT
                   && widx != IDX_IRQ_MASK) begin
        unmapped_w = 1'b1;
      end
      st_d.rsp.bvalid = 1'b1;
      st_d.rsp.bresp = unmapped_w ? RESP_SLVERR : RESP_OKAY;
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
    end
    if (st_q.rsp.bvalid && axi_req.bready) begin
      st_d.rsp.bvalid = 1'b0;
    end

    // Register read; result bit is read only
    case (ridx)
      IDX_OUT_CTRL: rbyte = st_q.out_ctrl;
      IDX_INTERVAL: rbyte = st_q.interval;
      IDX_STAT_CTRL: begin
        rbyte = 8'h00; // R17
        rbyte[SC_DMA] = st_q.dma_on;
        rbyte[SC_RIE] = st_q.rise_ie;
        rbyte[SC_FIE] = st_q.fall_ie;
        rbyte[SC_RISE] = st_q.rise_flag;
        rbyte[SC_FALL] = st_q.fall_flag;
        rbyte[SC_RES] = st_q.result; // R15
      end
      IDX_IRQ_STAT: rbyte = {6'h00, st_q.irq_stat};
      IDX_IRQ_MASK: rbyte = {6'h00, st_q.irq_mask};
      default: unmapped_r = 1'b1;
    endcase
    if (axi_req.arvalid && st_q.rsp.arready) begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rdata = {24'h00_0000, rbyte};
      st_d.rsp.rresp = unmapped_r ? RESP_SLVERR : RESP_OKAY;
      stat_clr = (ridx == IDX_IRQ_STAT);
    end
    if (st_q.rsp.rvalid && axi_req.rready) begin
      st_d.rsp.rvalid = 1'b0;
    end

    // Ready only while the previous answer is gone
    st_d.rsp.awready = ~st_d.aw_got & ~st_d.rsp.bvalid;
    st_d.rsp.wready = ~st_d.w_got & ~st_d.rsp.bvalid;
    st_d.rsp.arready = ~st_d.rsp.rvalid;

    // Flags: a set in the clear cycle wins
    st_d.rise_flag = (st_q.rise_flag & ~rise_clr) | rise_set; // R12
    st_d.fall_flag = (st_q.fall_flag & ~fall_clr) | fall_set; // R13

    // Sticky event status, cleared by read, set wins
    st_d.irq_stat = (stat_clr ? 2'h0 : st_q.irq_stat)
                    | {fall_set & ~st_q.fall_flag,
                       rise_set & ~st_q.rise_flag};

    // Pin drive and polarity mirror
    st_d.pin_oe = st_q.out_ctrl[OC_PIN] & pin_owned; // R2
    st_d.pin_out = st_q.result; // R2 R18

    // DMA and interrupt requests
    st_d.dma_req = st_q.dma_on & (st_q.rise_flag | st_q.fall_flag); // R9
    st_d.irq = (st_q.rise_ie & st_q.rise_flag) // R10 R19
               | (st_q.fall_ie & st_q.fall_flag) // R11
               | (|(st_q.irq_stat & st_q.irq_mask));
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.rsp.awready <= 1'b1;
      st_q.rsp.wready <= 1'b1;
      st_q.rsp.arready <= 1'b1;
      st_q.out_ctrl <= RST_BYTE;
      st_q.interval <= RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign axi_rsp = st_q.rsp;
  assign cmp_enable = st_q.enable;
  assign pin_out = st_q.pin_out;
  assign pin_oe = st_q.pin_oe;
  assign dma_req = st_q.dma_req;
  assign irq = st_q.irq;
endmodule

/* rtl/cmp_ctrl_pkg.sv */
// Constants, register map and carrier types of the comparator control block.
// Assumes a 25 MHz bus clock and an AXI4-Lite master with 32-bit data.
//
// Functional notes
// (R1) Source pick 0 routes filtered result; 1 routes raw result.
// (R2) Pin drive on and pin owned: drive selected output on the pin.
// (R3) Module on 0 keeps comparator off; 1 enables it.
// (R4) Same mux input on both ports disables the comparator automatically.
// (R5) Polarity flip 1 inverts comparator output; 0 passes it.
// (R6) Strobe mode off: filter samples every sample_interval bus clocks.
// (R7) Sample interval zero disables the output filter.
// (R8) Strobe mode on: ignore interval, sample on external strobe edges.
// (R9) DMA request enable set: request while rise or fall flag set.
// (R10) Rise interrupt enable set: interrupt while rise flag set.
// (R11) Fall interrupt enable set: interrupt while fall flag set.
// (R12) Rise flag sets on result rising edge; write 1 clears it.
// (R13) Fall flag sets on result falling edge; write 1 clears it.
// (R14) In stop mode the rise and fall flags follow levels.
// (R15) Result bit reads present output; writes to it ignored.
// (R16) Result bit resets to 0; reads polarity flip while module off.
// (R17) Status control bits 7 and 5 read as zero.
// (R18) Polarity mirrors to result bit and pin when pin drive off; the code mirrors it to both only while the comparator is off.
// (R19) Interrupt is OR of gated rise and fall flags, registered; the code also ORs in irq_stat masked by irq_mask.
package cmp_ctrl_pkg;
  localparam int ADDR_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_OUT_CTRL = 6'h01;
  localparam logic [5:0] IDX_INTERVAL = 6'h02;
  localparam logic [5:0] IDX_STAT_CTRL = 6'h03;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h06;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h07;
  // Output control fields
  localparam int OC_STROBE = 7;
  localparam int OC_FLIP = 3;
  localparam int OC_SRC = 2;
  localparam int OC_PIN = 1;
  localparam int OC_ON = 0;
  // Status control fields
  localparam int SC_DMA = 6;
  localparam int SC_RIE = 4;
  localparam int SC_FIE = 3;
  localparam int SC_RISE = 2;
  localparam int SC_FALL = 1;
  localparam int SC_RES = 0;
  // Interrupt status and mask layout
  localparam int IS_RISE = 0;
  localparam int IS_FALL = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;

  typedef struct packed {
    axi_rsp_s rsp;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wbyte;
    logic wen;
    logic [7:0] out_ctrl;
    logic [7:0] interval;
    logic dma_on;
    logic rise_ie;
    logic fall_ie;
    logic rise_flag;
    logic fall_flag;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic raw_s1;
    logic raw_s2;
    logic smp_s1;
    logic smp_s2;
    logic smp_prev;
    logic [7:0] cnt;
    logic filt;
    logic result;
    logic result_prev;
    logic enable;
    logic pin_out;
    logic pin_oe;
    logic dma_req;
    logic irq;
  } state_s;
endpackage

/* dv/cmp_ctrl_assertions.sv */
// Port checker for cmp_ctrl, bound onto every instance.
// Assumes one clk domain and an active high rst.
`timescale 1ns/1ns
module cmp_ctrl_assertions
  import cmp_ctrl_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire axi_req_s axi_req,
  input wire axi_rsp_s axi_rsp,
  // Analog and pin side
  input wire logic [2:0] plus_sel,
  input wire logic [2:0] minus_sel,
  input wire logic cmp_enable,
  input wire logic pin_owned,
  input wire logic pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bus takes
  sequence s_rd;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence s_wr;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  // Power gating and pin drive
  a_same_sel_off: assert property (
    plus_sel == minus_sel |=> !cmp_enable)
    else $error("enable with equal selects");
  a_en_cause: assert property (
    cmp_enable |-> $past(plus_sel != minus_sel))
    else $error("enable without distinct selects");
  a_oe_own: assert property (
    !pin_owned |=> !pin_oe)
    else $error("pin driven while not owned");
  // Register read and write answers
  a_sc_resv_zero: assert property (
    s_rd ##0 (axi_req.araddr == 8'h0c) |=>
      !axi_rsp.rdata[7] && !axi_rsp.rdata[5])
    else $error("reserved status bits set");
  a_rd_answer: assert property (
    s_rd |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_rd_once: assert property (
    axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read answer repeated");
  a_wr_answer: assert property (
    s_wr |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write answer timing");
  a_unmapped_err: assert property (
    s_rd ##0 (axi_req.araddr == 8'h3c) |=>
      axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == '0)
    else $error("unmapped read not refused");
endmodule

bind cmp_ctrl cmp_ctrl_assertions i_chk (
  .clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .plus_sel(plus_sel), .minus_sel(minus_sel), .cmp_enable(cmp_enable),
  .pin_owned(pin_owned), .pin_oe(pin_oe));

/* dv/cmp_ctrl_test.sv */
// Self-checking bench for the comparator control block.
// Assumes cmp_ctrl, its package and the bound checker.
`timescale 1ns/1ns
module cmp_ctrl_test
  import cmp_ctrl_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic raw_in, sample_in, pin_owned, stop_mode;
  logic [2:0] plus_sel, minus_sel;
  logic cmp_enable, pin_out, pin_oe, dma_req, irq;
  axi_req_s req;
  axi_rsp_s rsp;
  logic [7:0] rdat;
  logic [1:0] rres;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  // Ctrl byte, raw and plus, owned and minus, result enable oe
  logic [19:0] rows [8] = '{20'h0_19a6, 20'h0_99a2, 20'h0_81a4,
    20'h0_31a3, 20'h0_3926, 20'h0_1bb0, 20'h0_59a6, 20'h0_a1a5};

  // Device under test
  cmp_ctrl i_dut (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
    .raw_in(raw_in), .sample_in(sample_in), .plus_sel(plus_sel),
    .minus_sel(minus_sel), .cmp_enable(cmp_enable), .pin_owned(pin_owned),
    .stop_mode(stop_mode), .pin_out(pin_out), .pin_oe(pin_oe),
    .dma_req(dma_req), .irq(irq));

  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic cb(input string n, input logic s, e);
    chk(n, {7'h00, s}, {7'h00, e});
  endtask

  // Bus cycles; bready and rready stay high
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= {24'h00_0000, d};
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    while (req.awvalid || req.wvalid) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end
    while (!rsp.bvalid) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    do @(posedge clk); while (!rsp.arready);
    req.arvalid <= 1'h0;
    do @(posedge clk); while (!rsp.rvalid);
    rdat = rsp.rdata[7:0];
    rres = rsp.rresp;
  endtask
  task automatic rc(input logic [7:0] a, e);
    rd(a);
    chk($sformatf("reg %h", a), rdat, e);
  endtask
  task automatic pulse();
    sample_in <= 1'h1;
    repeat (4) @(posedge clk);
    sample_in <= 1'h0;
    repeat (8) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    req = '0;
    req.wstrb = 4'hf;
    req.bready = 1'h1;
    req.rready = 1'h1;
    {raw_in, sample_in, pin_owned, stop_mode} = 4'h0;
    plus_sel = 3'h1;
    minus_sel = 3'h2;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rc(8'h04, 8'h00);
    rc(8'h0c, 8'h00);
    rd(8'h3c);
    chk("unmapped", {6'h00, rres}, {6'h00, RESP_SLVERR});
    foreach (rows[i]) begin
      raw_in <= rows[i][11];
      plus_sel <= rows[i][10:8];
      pin_owned <= rows[i][7];
      minus_sel <= rows[i][6:4];
      wr(8'h04, rows[i][19:12]);
      repeat (6) @(posedge clk);
      rd(8'h0c);
      cb("result", rdat[0], rows[i][2]);
      cb("enable", cmp_enable, rows[i][1]);
      cb("pin_oe", pin_oe, rows[i][0]);
      cb("pin_out", pin_out, rows[i][2]);
    end
    // Edge flags, enables and DMA request
    raw_in <= 1'h0;
    wr(8'h04, 8'h01);
    repeat (6) @(posedge clk);
    wr(8'h0c, 8'h5e);
    rd(8'h18);
    cb("irq idle", irq, 1'h0);
    raw_in <= 1'h1;
    repeat (8) @(posedge clk);
    cb("irq rise", irq, 1'h1);
    cb("dma", dma_req, 1'h1);
    rc(8'h0c, 8'h5d);
    wr(8'h0c, 8'h5c);
    rc(8'h0c, 8'h59);
    cb("irq clear", irq, 1'h0);
    raw_in <= 1'h0;
    repeat (8) @(posedge clk);
    cb("irq fall", irq, 1'h1);
    rc(8'h0c, 8'h5a);
    // Sticky status, mask and read clear
    rc(8'h18, 8'h03);
    rc(8'h18, 8'h00);
    wr(8'h0c, 8'h06);
    wr(8'h1c, 8'h03);
    raw_in <= 1'h1;
    repeat (8) @(posedge clk);
    cb("irq unmasked", irq, 1'h1);
    cb("dma off", dma_req, 1'h0);
    rc(8'h1c, 8'h03);
    wr(8'h1c, 8'h00);
    repeat (2) @(posedge clk);
    cb("irq masked", irq, 1'h0);
    rd(8'h18);
    // Level flags in stop mode
    stop_mode <= 1'h1;
    wr(8'h0c, 8'h06);
    rc(8'h0c, 8'h05);
    stop_mode <= 1'h0;
    // External strobe, then interval sampling
    wr(8'h04, 8'h81);
    pulse();
    raw_in <= 1'h0;
    repeat (8) @(posedge clk);
    rd(8'h0c);
    cb("held", rdat[0], 1'h1);
    pulse();
    rd(8'h0c);
    cb("sampled", rdat[0], 1'h0);
    wr(8'h08, 8'h04);
    wr(8'h04, 8'h01);
    raw_in <= 1'h1;
    repeat (12) @(posedge clk);
    rd(8'h0c);
    cb("interval", rdat[0], 1'h1);
    rc(8'h08, 8'h04);
    // Mid-run reset returns registers, pin_oe and cmp_enable to zero
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    cb("rst oe", pin_oe, 1'h0);
    cb("rst en", cmp_enable, 1'h0);
    rc(8'h04, 8'h00);
    rc(8'h08, 8'h00);
    rc(8'h0c, 8'h00);
    stop_test();
  end
endmodule
